// [logic/sfc_command_engine.v]
// Serial flash command engine: command decode, buffers, array, status and readout
// Function
// - Opcode 52H or D2H reads any page directly, buffers untouched.
// - Page read header is 24 address bits then 32 don't-care bits.
// - After the 32 don't-care bits each clock shifts out data from addressed byte.
// - Page read wraps to byte zero of the same page.
// - Chip select rise ends any read and releases the serial output.
// - 54H/D4H reads first buffer, 56H/D6H reads second buffer.
// - Buffer read: 15 don't-care, nine byte bits, eight don't-care, then data.
// - Buffer read wraps from byte 263 to byte zero.
// - 57H/D7H shifts status MSB first right after the opcode.
// - Status repeats while clocked, each repetition freshly sampled.
// - Status bits 5..2 hold a fixed density code; bits 1..0 reserved.
// - With clock parked after bit 7, output follows ready, rising when done.
// - Buffer write 84H/87H stores data bytes with wrap until chip select rises.
// - 83H/86H erases and programs page from buffer on chip select rise.
// - 88H/89H programs page from buffer without erase on chip select rise.
// - 81H erases the selected page to ones on chip select rise.
// - 50H erases a block of eight pages to ones on chip select rise.
// - 82H/85H writes buffer with wrap, then erase-programs page on rise.
// - Commands start at chip select fall, eight-bit opcode, MSB first.
// - Input sampled on clock rise, output changes on clock fall.
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_command_engine #(
    parameter ERASE_PROGRAM_TIME_NS = `SFC_ERASE_PROGRAM_TIME_NS,
    parameter PROGRAM_TIME_NS = `SFC_PROGRAM_TIME_NS,
    parameter PAGE_ERASE_TIME_NS = `SFC_PAGE_ERASE_TIME_NS,
    parameter BLOCK_ERASE_TIME_NS = `SFC_BLOCK_ERASE_TIME_NS
) (
    // Clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // Serial host pins
    input wire cs_n_i,
    input wire sck_i,
    input wire si_i,
    // Serial output with its enable
    output wire so_o,
    output wire so_oe_o
);

    // Longest times round down, never below one cycle
    localparam [31:0] EP_RAW = ERASE_PROGRAM_TIME_NS * `SFC_CLK_MHZ / 1000;
    localparam [31:0] P_RAW = PROGRAM_TIME_NS * `SFC_CLK_MHZ / 1000;
    localparam [31:0] PE_RAW = PAGE_ERASE_TIME_NS * `SFC_CLK_MHZ / 1000;
    localparam [31:0] BE_RAW = BLOCK_ERASE_TIME_NS * `SFC_CLK_MHZ / 1000;
    localparam [31:0] EP_CYCLES = (EP_RAW < 1) ? 32'h0000_0001 : EP_RAW;
    localparam [31:0] P_CYCLES = (P_RAW < 1) ? 32'h0000_0001 : P_RAW;
    localparam [31:0] PE_CYCLES = (PE_RAW < 1) ? 32'h0000_0001 : PE_RAW;
    localparam [31:0] BE_CYCLES = (BE_RAW < 1) ? 32'h0000_0001 : BE_RAW;

    // Array engine states and operations
    localparam ST_IDLE = 1'b0;
    localparam ST_BUSY = 1'b1;
    localparam [1:0] ENG_ERASE_PROG = 2'b00;
    localparam [1:0] ENG_PROG = 2'b01;
    localparam [1:0] ENG_ERASE = 2'b10;

    // Step counts of one page and of one block
    localparam [11:0] PAGE_STEPS = 12'h108;
    localparam [11:0] BLOCK_STEPS = 12'h840;

    // Storage: main array and the two buffers
    reg [7:0] mem_q [0:`SFC_MEM_WORDS-1];
    reg [7:0] buf1_q [0:`SFC_PAGE_BYTES-1];
    reg [7:0] buf2_q [0:`SFC_PAGE_BYTES-1];

    // Serial front end
    wire [`SFC_PIN_COUNT-1:0] pins_w;
    wire cs_n_s;
    wire sck_s;
    wire si_s;
    reg sck_prev_q;
    reg cs_prev_q;
    wire sck_rise;
    wire sck_fall;
    wire cs_fall;
    wire cs_rise;

    // Command state
    reg [15:0] bit_cnt_q;
    reg [31:0] sr_q;
    reg [7:0] op_q;
    reg [23:0] addr_q;
    reg [8:0] ptr_q;
    reg [2:0] out_bit_q;
    reg so_q;
    reg oe_q;
    reg bit7_shown_q;
    wire [7:0] in_byte;
    wire [15:0] rd_start;
    wire is_status;

    // Array engine state
    reg eng_state_q;
    reg [1:0] eng_op_q;
    reg eng_buf2_q;
    reg [19:0] eng_base_q;
    reg [11:0] step_q;
    reg [11:0] steps_q;
    reg [31:0] timer_q;
    reg comp_q;

    // Read data and status
    reg [7:0] rd_byte;
    wire [7:0] status_byte;
    wire [19:0] page_word;

    // Serial clock count at which output starts, 0 when opcode reads nothing
    function [15:0] read_start;
        input [7:0] op;
        begin
            if (op == `SFC_OP_PAGE_READ_A || op == `SFC_OP_PAGE_READ_B) begin
                read_start = `SFC_PAGE_READ_START;
            end else if (op == `SFC_OP_BUF1_READ_A || op == `SFC_OP_BUF1_READ_B ||
                         op == `SFC_OP_BUF2_READ_A || op == `SFC_OP_BUF2_READ_B) begin
                read_start = `SFC_BUF_READ_START;
            end else if (op == `SFC_OP_STATUS_A || op == `SFC_OP_STATUS_B) begin
                read_start = `SFC_STATUS_START;
            end else begin
                read_start = 16'h0000;
            end
        end
    endfunction

    // Opcodes that address the second buffer
    function second_buf;
        input [7:0] op;
        begin
            second_buf = (op == `SFC_OP_BUF2_READ_A) || (op == `SFC_OP_BUF2_READ_B) ||
                         (op == `SFC_OP_BUF2_WRITE) || (op == `SFC_OP_BUF2_EP) ||
                         (op == `SFC_OP_BUF2_P) || (op == `SFC_OP_THRU_BUF2);
        end
    endfunction

    // Opcodes whose data phase fills a buffer
    function buf_write;
        input [7:0] op;
        begin
            buf_write = (op == `SFC_OP_BUF1_WRITE) || (op == `SFC_OP_BUF2_WRITE) ||
                        (op == `SFC_OP_THRU_BUF1) || (op == `SFC_OP_THRU_BUF2);
        end
    endfunction

    sfc_pin_sync #(
        .WIDTH(`SFC_PIN_COUNT)
    ) u_sync (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({si_i, sck_i, cs_n_i}),
        .sync_o(pins_w)
    );

    // Edges are taken from the second flop only
    assign cs_n_s = pins_w[`SFC_PIN_CS];
    assign sck_s = pins_w[`SFC_PIN_SCK];
    assign si_s = pins_w[`SFC_PIN_SI];
    assign sck_rise = sck_s & ~sck_prev_q & ~cs_n_s;
    assign sck_fall = ~sck_s & sck_prev_q & ~cs_n_s;
    assign cs_fall = ~cs_n_s & cs_prev_q;
    assign cs_rise = cs_n_s & ~cs_prev_q;

    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            sck_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cs_prev_q <= cs_n_s;
        end
    end

    // Fixed fields plus live ready flag; compare flag holds its reset value
    assign status_byte = {~eng_state_q, comp_q, `SFC_DENSITY_CODE, `SFC_ST_RESERVED};
    assign in_byte = {sr_q[6:0], si_s};
    assign rd_start = read_start(op_q);
    assign is_status = (op_q == `SFC_OP_STATUS_A) || (op_q == `SFC_OP_STATUS_B);
    // Product kept at 20 bits; the last page ends below the array size
    assign page_word = {9'h000, addr_q[19:9]} * {8'h00, PAGE_STEPS};

    // Byte under the read pointer; page read bypasses both buffers
    always @* begin
        rd_byte = 8'hFF;
        if (op_q == `SFC_OP_PAGE_READ_A || op_q == `SFC_OP_PAGE_READ_B) begin
            rd_byte = mem_q[page_word + {11'h000, ptr_q}];
        end else if (op_q == `SFC_OP_BUF1_READ_A || op_q == `SFC_OP_BUF1_READ_B) begin
            rd_byte = buf1_q[ptr_q];
        end else if (op_q == `SFC_OP_BUF2_READ_A || op_q == `SFC_OP_BUF2_READ_B) begin
            rd_byte = buf2_q[ptr_q];
        end else if (is_status) begin
            rd_byte = status_byte;
        end
    end

    // Serial command process: shift in on rise, shift out on fall
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            bit_cnt_q <= 16'h0000;
            sr_q <= 32'h0000_0000;
            op_q <= 8'h00;
            addr_q <= 24'h00_0000;
            ptr_q <= 9'h000;
            out_bit_q <= 3'h0;
            so_q <= 1'b0;
            oe_q <= 1'b0;
            bit7_shown_q <= 1'b0;
        end else if (cs_rise) begin
            oe_q <= 1'b0;
            bit7_shown_q <= 1'b0;
        end else if (cs_fall) begin
            // New frame starts with a fresh opcode
            bit_cnt_q <= 16'h0000;
            op_q <= 8'h00;
            out_bit_q <= 3'h0;
            bit7_shown_q <= 1'b0;
        end else if (sck_rise) begin
            sr_q <= {sr_q[30:0], si_s};
            if (bit_cnt_q != 16'hFFFF) begin
                bit_cnt_q <= bit_cnt_q + 16'h0001;
            end
            if (bit_cnt_q == `SFC_OPCODE_BITS - 16'h0001) begin
                op_q <= in_byte;
            end
            // All 24 address bits are kept; the pointer takes the low nine
            if (bit_cnt_q == `SFC_HEADER_BITS - 16'h0001) begin
                addr_q <= {sr_q[22:0], si_s};
                ptr_q <= {sr_q[7:0], si_s};
            end
            // Buffer data bytes, wrapping at the end of the buffer
            if (buf_write(op_q) && bit_cnt_q >= `SFC_HEADER_BITS && bit_cnt_q[2:0] == 3'h7) begin
                if (ptr_q <= `SFC_LAST_BYTE) begin
                    if (second_buf(op_q)) begin
                        buf2_q[ptr_q] <= in_byte;
                    end else begin
                        buf1_q[ptr_q] <= in_byte;
                    end
                end
                ptr_q <= (ptr_q >= `SFC_LAST_BYTE) ? 9'h000 : ptr_q + 9'h001;
            end
        end else if (sck_fall && rd_start != 16'h0000 && bit_cnt_q >= rd_start) begin
            // Status is resampled per bit, so each repetition is fresh
            so_q <= rd_byte[~out_bit_q];
            oe_q <= 1'b1;
            out_bit_q <= out_bit_q + 3'h1;
            bit7_shown_q <= is_status && (out_bit_q == 3'h0);
            if (out_bit_q == 3'h7 && !is_status) begin
                ptr_q <= (ptr_q >= `SFC_LAST_BYTE) ? 9'h000 : ptr_q + 9'h001;
            end
        end else if (bit7_shown_q) begin
            // Parked clock after bit 7: track ready so polling sees the rise
            so_q <= ~eng_state_q;
        end
    end

    assign so_o = so_q;
    assign so_oe_o = oe_q;

    // Array engine: launched on chip select rise, steps one byte a cycle
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            eng_state_q <= ST_IDLE;
            eng_op_q <= ENG_ERASE;
            eng_buf2_q <= 1'b0;
            eng_base_q <= 20'h0_0000;
            step_q <= 12'h000;
            steps_q <= 12'h000;
            timer_q <= 32'h0000_0000;
            comp_q <= `SFC_ST_COMP_RESET;
        end else begin
            case (eng_state_q)
                ST_IDLE: begin
                    // A busy device drops a second array command
                    if (cs_rise && bit_cnt_q >= `SFC_HEADER_BITS) begin
                        eng_buf2_q <= second_buf(op_q);
                        eng_base_q <= page_word;
                        step_q <= 12'h000;
                        steps_q <= PAGE_STEPS;
                        if (op_q == `SFC_OP_BUF1_EP || op_q == `SFC_OP_BUF2_EP ||
                            op_q == `SFC_OP_THRU_BUF1 || op_q == `SFC_OP_THRU_BUF2) begin
                            eng_op_q <= ENG_ERASE_PROG;
                            timer_q <= EP_CYCLES;
                            eng_state_q <= ST_BUSY;
                        end else if (op_q == `SFC_OP_BUF1_P || op_q == `SFC_OP_BUF2_P) begin
                            eng_op_q <= ENG_PROG;
                            timer_q <= P_CYCLES;
                            eng_state_q <= ST_BUSY;
                        end else if (op_q == `SFC_OP_PAGE_ERASE) begin
                            eng_op_q <= ENG_ERASE;
                            timer_q <= PE_CYCLES;
                            eng_state_q <= ST_BUSY;
                        end else if (op_q == `SFC_OP_BLOCK_ERASE) begin
                            eng_op_q <= ENG_ERASE;
                            eng_base_q <= {9'h000, addr_q[19:12], 3'h0} * {8'h00, PAGE_STEPS};
                            steps_q <= BLOCK_STEPS;
                            timer_q <= BE_CYCLES;
                            eng_state_q <= ST_BUSY;
                        end
                    end
                end
                ST_BUSY: begin
                    if (step_q != steps_q) begin
                        if (eng_op_q == ENG_ERASE) begin
                            mem_q[eng_base_q + {8'h00, step_q}] <= 8'hFF;
                        end else if (eng_op_q == ENG_PROG) begin
                            // Programming only clears bits; erased page assumed
                            mem_q[eng_base_q + {8'h00, step_q}] <= mem_q[eng_base_q + {8'h00, step_q}] &
                                (eng_buf2_q ? buf2_q[step_q[8:0]] : buf1_q[step_q[8:0]]);
                        end else begin
                            mem_q[eng_base_q + {8'h00, step_q}] <=
                                eng_buf2_q ? buf2_q[step_q[8:0]] : buf1_q[step_q[8:0]];
                        end
                        step_q <= step_q + 12'h001;
                    end
                    if (timer_q > 32'h0000_0001) begin
                        timer_q <= timer_q - 32'h0000_0001;
                    end else if (step_q == steps_q) begin
                        eng_state_q <= ST_IDLE;
                    end
                end
                default: begin
                    eng_state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// [logic/sfc_regs.vh]
// Constants of the serial flash command engine: opcodes, frame lengths, status layout, timing
`ifndef SFC_REGS_VH
`define SFC_REGS_VH

// System clock rate in MHz, used to turn array times into cycle counts
`define SFC_CLK_MHZ 200

// Default array operation times in ns; top-level parameters carry them
`define SFC_ERASE_PROGRAM_TIME_NS 20000
`define SFC_PROGRAM_TIME_NS 14000
`define SFC_PAGE_ERASE_TIME_NS 8000
`define SFC_BLOCK_ERASE_TIME_NS 12000

// Array geometry
`define SFC_PAGES 2048
`define SFC_PAGE_BYTES 264
`define SFC_LAST_BYTE 9'h107
`define SFC_BLOCK_PAGES 8
`define SFC_MEM_WORDS 540672

// Frame lengths in serial clocks
`define SFC_OPCODE_BITS 16'h0008
`define SFC_HEADER_BITS 16'h0020
`define SFC_PAGE_READ_START 16'h0040
`define SFC_BUF_READ_START 16'h0028
`define SFC_STATUS_START 16'h0008

// Read opcodes
`define SFC_OP_PAGE_READ_A 8'h52
`define SFC_OP_PAGE_READ_B 8'hD2
`define SFC_OP_BUF1_READ_A 8'h54
`define SFC_OP_BUF1_READ_B 8'hD4
`define SFC_OP_BUF2_READ_A 8'h56
`define SFC_OP_BUF2_READ_B 8'hD6
`define SFC_OP_STATUS_A 8'h57
`define SFC_OP_STATUS_B 8'hD7

// Program and erase opcodes
`define SFC_OP_BUF1_WRITE 8'h84
`define SFC_OP_BUF2_WRITE 8'h87
`define SFC_OP_BUF1_EP 8'h83
`define SFC_OP_BUF2_EP 8'h86
`define SFC_OP_BUF1_P 8'h88
`define SFC_OP_BUF2_P 8'h89
`define SFC_OP_PAGE_ERASE 8'h81
`define SFC_OP_BLOCK_ERASE 8'h50
`define SFC_OP_THRU_BUF1 8'h82
`define SFC_OP_THRU_BUF2 8'h85

// Status byte layout
`define SFC_ST_READY 7
`define SFC_ST_COMP 6
`define SFC_ST_COMP_RESET 1'b0
// Density code, value arbitrary
`define SFC_DENSITY_CODE 4'hA
`define SFC_ST_RESERVED 2'h0

// Pin synchroniser lanes
`define SFC_PIN_CS 0
`define SFC_PIN_SCK 1
`define SFC_PIN_SI 2
`define SFC_PIN_COUNT 3

`endif

// [logic/sfc_pin_sync.v]
// Two-flop synchroniser for the serial pins
`timescale 1ns/1ps
module sfc_pin_sync #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // Pins in, synchronised levels out
    input wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : lane
            // Reset to ones: chip select idle high, others harmless
            always @(posedge clock_i) begin
                if (sys_rst_i) begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                end else begin
                    meta_q[g] <= pin_i[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;

endmodule

// [verification/sfc_checker_props.sv]
// Port-level checker of the serial flash command engine
`timescale 1ns/1ps
`include "sfc_regs.vh"
module sfc_checker_props (
    // Clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // Serial pins as seen at the ports
    input wire cs_n_i,
    input wire sck_i,
    input wire si_i,
    input wire so_o,
    input wire so_oe_o
);
    logic sck_q;
    logic [15:0] rises_q;
    logic [7:0] op_q;
    logic [2:0] idx;
    logic is_status;
    logic is_buf;
    logic is_page;
    logic [7:0] st_exp;
    // Raw pin edges counted here; the design sees them two flops later
    always @(posedge clock_i) begin
        sck_q <= sck_i;
        if (sys_rst_i || cs_n_i) begin
            rises_q <= 16'h0000;
            op_q <= 8'h00;
        end else if (sck_i && !sck_q) begin
            rises_q <= rises_q + 16'h0001;
            if (rises_q < 16'h0008) op_q <= {op_q[6:0], si_i};
        end
    end
    // Opcode classes and the status bit expected on the line
    assign is_status = (op_q == 8'h57) || (op_q == 8'hD7);
    assign is_buf = (op_q == 8'h54) || (op_q == 8'hD4) || (op_q == 8'h56) || (op_q == 8'hD6);
    assign is_page = (op_q == 8'h52) || (op_q == 8'hD2);
    assign idx = 3'h7 - rises_q[2:0];
    assign st_exp = {1'b1, `SFC_ST_COMP_RESET, `SFC_DENSITY_CODE, `SFC_ST_RESERVED};

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_cs_rise;
        $rose(cs_n_i);
    endsequence
    sequence s_line_off;
        !so_oe_o ##1 !so_oe_o;
    endsequence
    sequence s_status_bit;
        is_status && $rose(sck_i) && (rises_q >= 16'h0008);
    endsequence

    property p_reset_quiet;
        $fell(sys_rst_i) |-> !so_oe_o && !so_o;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
    property p_cs_rise_release;
        s_cs_rise |-> ##[1:4] s_line_off;
    endproperty
    a_cs_rise_release: assert property (p_cs_rise_release) else $error("output kept after select rise");
    property p_oe_needs_cs;
        so_oe_o |-> !$past(cs_n_i, 4);
    endproperty
    a_oe_needs_cs: assert property (p_oe_needs_cs) else $error("output driven while deselected");
    property p_so_on_low;
        (so_oe_o && $changed(so_o)) |-> !sck_i;
    endproperty
    a_so_on_low: assert property (p_so_on_low) else $error("output changed while clock high");
    property p_oe_rise_low;
        $rose(so_oe_o) |-> !sck_i && !cs_n_i;
    endproperty
    a_oe_rise_low: assert property (p_oe_rise_low) else $error("output started off a falling edge");
    property p_oe_rise_count;
        $rose(so_oe_o) |-> (is_status && rises_q == 16'h0008) || (is_buf && rises_q == 16'h0028)
            || (is_page && rises_q == 16'h0040);
    endproperty
    a_oe_rise_count: assert property (p_oe_rise_count) else $error("readout began at wrong bit");
    property p_status_code;
        s_status_bit ##0 (idx >= 3'h2 && idx <= 3'h5) |-> so_o == st_exp[idx];
    endproperty
    a_status_code: assert property (p_status_code) else $error("density code bit wrong");
    property p_status_comp;
        s_status_bit ##0 (idx == 3'h6) |-> so_o == st_exp[6];
    endproperty
    a_status_comp: assert property (p_status_comp) else $error("compare bit wrong");
endmodule

bind sfc_command_engine sfc_checker_props chk_u (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .cs_n_i(cs_n_i),
    .sck_i(sck_i),
    .si_i(si_i),
    .so_o(so_o),
    .so_oe_o(so_oe_o)
);

// [verification/sfc_host_model.sv]
// Serial host model, mode 0, driving the device pins
`timescale 1ns/1ps
module sfc_host_model #(
    parameter HALF = 16
) (
    // Clock
    input wire logic clock_i,
    // Pins toward the device
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o,
    // Serial output back from the device
    input wire logic so_i,
    input wire logic so_oe_i
);
    // Idle: deselected, clock parked low
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Frame opens on a select fall and stays low until stop
    task automatic start();
        wait_clk(1);
        cs_n_o <= 1'b0;
        wait_clk(HALF);
    endtask
    task automatic stop();
        wait_clk(HALF);
        cs_n_o <= 1'b1;
        si_o <= ~si_o; // Idle input keeps moving, never trusted
        wait_clk(HALF);
    endtask
    // Data set at the fall, held across the rise, MSB first
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            si_o <= b[i];
            wait_clk(HALF);
            sck_o <= 1'b1;
            wait_clk(HALF);
            sck_o <= 1'b0;
        end
    endtask
    // Sampled just before the rise; undriven line reads unknown
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            wait_clk(HALF);
            b[i] = so_oe_i ? so_i : 1'bx;
            sck_o <= 1'b1;
            wait_clk(HALF);
            sck_o <= 1'b0;
        end
    endtask
    // Clock parked low after the top bit; no new array work until ready
    task automatic poll(output logic busy_seen, output logic ready);
        busy_seen = 1'b0;
        ready = 1'b0;
        start();
        put_byte(8'hD7);
        for (int n = 0; n < 3000 && ready !== 1'b1; n++) begin
            wait_clk(1);
            if (so_oe_i && so_i === 1'b0) busy_seen = 1'b1;
            if (so_oe_i && so_i === 1'b1 && n > 4) ready = 1'b1;
        end
        stop();
    endtask
endmodule

// [verification/serial_flash_command_engine_tb_top.sv]
// Testbench: buffer, status and array traffic through the host model
`timescale 1ns/1ps
`include "sfc_regs.vh"
module serial_flash_command_engine_tb_top;
    logic clock_i;
    logic sys_rst_i;
    wire cs_n;
    wire sck;
    wire si;
    wire so;
    wire so_oe;
    int failures = 0;
    int n_tests = 0;
    localparam logic [7:0] ST_IDLE = {1'b1, `SFC_ST_COMP_RESET, `SFC_DENSITY_CODE, `SFC_ST_RESERVED};
    // Rows: write opcode, read opcode, start byte, first data value
    logic [32:0] buf_rows [4] = '{
        {8'h84, 8'h54, 9'h000, 8'h11},
        {8'h87, 8'hD6, 9'h106, 8'h22},
        {8'h84, 8'hD4, 9'h080, 8'h33},
        {8'h87, 8'h56, 9'h001, 8'h44}};
    // Rows: opcode, page, start byte, data value, read-back byte, three expected bytes
    logic [68:0] arr_rows [8] = '{
        {8'h85, 11'h005, 9'h107, 8'h31, 9'h107, 24'h313233},
        {8'h81, 11'h005, 9'h155, 8'h00, 9'h107, 24'hFFFFFF},
        {8'h89, 11'h005, 9'h155, 8'h00, 9'h107, 24'h313233},
        {8'h83, 11'h006, 9'h155, 8'h00, 9'h000, 24'h111213},
        {8'h50, 11'h006, 9'h1FF, 8'h00, 9'h000, 24'hFFFFFF},
        {8'h88, 11'h006, 9'h155, 8'h00, 9'h080, 24'h333435},
        {8'h82, 11'h007, 9'h000, 8'h51, 9'h000, 24'h515253},
        {8'h86, 11'h007, 9'h106, 8'h00, 9'h106, 24'h223132}};

    // Times shortened so a busy period is 2200 cycles
    sfc_command_engine #(
        .ERASE_PROGRAM_TIME_NS(11000),
        .PROGRAM_TIME_NS(11000),
        .PAGE_ERASE_TIME_NS(11000),
        .BLOCK_ERASE_TIME_NS(11000)
    ) dut_u (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .so_o(so), .so_oe_o(so_oe));
    sfc_host_model host_u (
        .clock_i(clock_i), .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so), .so_oe_i(so_oe));

    // 200 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Opcode then three address bytes; frame left open
    task automatic cmd(input logic [7:0] op, input logic [23:0] addr);
        host_u.start();
        host_u.put_byte(op);
        for (int i = 2; i >= 0; i--) host_u.put_byte(addr[i*8 +: 8]);
    endtask
    task automatic read3(input logic [7:0] op, input logic [23:0] addr, input int dummies, input logic [23:0] exp);
        logic [7:0] b;
        cmd(op, addr);
        repeat (dummies) host_u.put_byte(8'hA5);
        for (int i = 2; i >= 0; i--) begin
            host_u.get_byte(b);
            check(b, exp[i*8 +: 8]);
        end
        host_u.stop();
    endtask
    // A hang here ends the run at once
    task automatic wait_ready();
        logic busy_seen;
        logic ready;
        host_u.poll(busy_seen, ready);
        check({7'h00, busy_seen}, 8'h01);
        check({7'h00, ready}, 8'h01);
        if (ready !== 1'b1) conclude();
    endtask

    // Main sequence
    initial begin
        logic [32:0] r;
        logic [68:0] a;
        logic [7:0] b;
        logic busy;
        logic rdy;
        sys_rst_i = 1'b1;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        check({6'h00, so_oe, so}, 8'h00);
        foreach (buf_rows[k]) begin
            r = buf_rows[k];
            cmd(r[32:25], {15'h2AAA, r[16:8]});
            for (int i = 0; i < 3; i++) host_u.put_byte(r[7:0] + 8'(i));
            host_u.stop();
            read3(r[24:17], {15'h2AAA, r[16:8]}, 1, {r[7:0], r[7:0] + 8'h01, r[7:0] + 8'h02});
            $display("Buffer case %0d done", k);
        end
        // Status read twice in a frame, both opcodes, idle device
        for (int k = 0; k < 2; k++) begin
            host_u.start();
            host_u.put_byte(k[0] ? 8'h57 : 8'hD7);
            repeat (2) begin
                host_u.get_byte(b);
                check(b, ST_IDLE);
            end
            host_u.stop();
        end
        $display("Status case done");
        foreach (arr_rows[k]) begin
            a = arr_rows[k];
            cmd(a[68:61], {4'hF, a[60:50], a[49:41]});
            if (a[68:61] == 8'h82 || a[68:61] == 8'h85) begin
                for (int i = 0; i < 3; i++) host_u.put_byte(a[40:33] + 8'(i));
            end
            host_u.stop();
            wait_ready();
            read3(k[0] ? 8'hD2 : 8'h52, {4'hF, a[60:50], a[32:24]}, 4, a[23:0]);
            $display("Array case %0d done", k);
        end
        // Reset in mid busy period: outputs quiet, device ready at once
        cmd(8'h81, {4'hF, 11'h005, 9'h000});
        host_u.stop();
        sys_rst_i <= 1'b1;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        check({6'h00, so_oe, so}, 8'h00);
        host_u.poll(busy, rdy);
        check({7'h00, busy}, 8'h00);
        check({7'h00, rdy}, 8'h01);
        $display("Reset case done");
        conclude();
    end
endmodule
